// ### hdl/flash_spm_pkg.sv
package flash_spm_pkg;
  localparam int unsigned PC_W            = 17;
  localparam int unsigned PAGE_SEL_W      = 10;
  localparam int unsigned WORD_SEL_W      = 7;
  localparam int unsigned PAGE_WORDS      = 128;
  localparam logic [16:0] HALT_REGION_START = 17'h1_F000;
  localparam logic [16:0] BOOT_START_512  = 17'h1_FE00;
  localparam logic [16:0] BOOT_START_1024 = 17'h1_FC00;
  localparam logic [16:0] BOOT_START_2048 = 17'h1_F800;
  localparam logic [16:0] BOOT_START_4096 = 17'h1_F000;
  // control and status bit positions
  localparam int unsigned BIT_IRQ_EN  = 7;
  localparam int unsigned BIT_BUSY    = 6;
  localparam int unsigned BIT_SIG     = 5;
  localparam int unsigned BIT_REEN    = 4;
  localparam int unsigned BIT_LOCK    = 3;
  localparam int unsigned BIT_PWRITE  = 2;
  localparam int unsigned BIT_PERASE  = 1;
  localparam int unsigned BIT_ENABLE  = 0;
  localparam logic [4:0] PAT_REEN   = 5'h11;
  localparam logic [4:0] PAT_LOCK   = 5'h09;
  localparam logic [4:0] PAT_PWRITE = 5'h05;
  localparam logic [4:0] PAT_PERASE = 5'h03;
  localparam logic [4:0] PAT_FILL   = 5'h01;
  localparam logic [2:0] STORE_WINDOW = 3'h4;
  localparam logic [1:0] LOAD_WINDOW  = 2'h3;
  localparam int unsigned PROG_CYCLES_DEFAULT = 64;
  localparam logic [7:0] LOCK_RESET = 8'hFF;
  localparam logic [7:0] CSR_RESET  = 8'h00;
  // controller register offsets (APB byte addresses)
  localparam logic [7:0] OFS_CSR    = 8'h00;
  localparam logic [7:0] OFS_PTR    = 8'h04;
  localparam logic [7:0] OFS_DATA   = 8'h08;
  localparam logic [7:0] OFS_OP     = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_GIE    = 8'h14;
  localparam int unsigned OP_STORE  = 0;
  localparam int unsigned OP_LOAD   = 1;
  typedef enum logic [1:0] {IDLE, PROG} prog_state_type;
endpackage : flash_spm_pkg

// ### hdl/flash_spm_if.sv
`timescale 1ns/1ns
interface flash_spm_if;
  logic        csrWrite;
  logic [7:0]  csrWdata;
  logic [7:0]  csrRdata;
  logic        storeReq;
  logic        loadReq;
  logic [15:0] ptr;
  logic [1:0]  extPage;
  logic [7:0]  gpLowData;
  logic [7:0]  gpHighData;
  logic        globalIrqEn;
  logic [7:0]  loadData;
  logic        loadSpecial;
  logic        readyIrq;
  logic        regionBusy;
  logic        cpuHalt;
  modport device (input csrWrite, csrWdata, storeReq, loadReq, ptr, extPage, gpLowData, gpHighData,
                  globalIrqEn, output csrRdata, loadData, loadSpecial, readyIrq, regionBusy, cpuHalt);
  modport cpu (output csrWrite, csrWdata, storeReq, loadReq, ptr, extPage, gpLowData, gpHighData,
               globalIrqEn, input csrRdata, loadData, loadSpecial, readyIrq, regionBusy, cpuHalt);
endinterface : flash_spm_if

// ### hdl/flash_spm_device.sv
`timescale 1ns/1ns
// Overview of operation
// - boot size code picks boot start
// - below 0x1F000 concurrent, above halting region
// - program counter is 17 bits
// - 128-word pages, seven word bits
// - page from pointer 17:8, word 7:1
// - pointer bit 0 selects lock/fuse load byte, bits 1:0 the signature byte
// - pointer bits 17:16 from extended page
// - ready interrupt while store enable clear
// - erase/write to concurrent region sets busy
// - busy clears on re-enable or fill
// - signature read; store has no effect
// - re-enable only after programming finished
// - re-enable during fill discards buffer
// - lock-set store programs boot lock bits
// - load returns lock or fuse bits
// - page write from temporary buffer
// - page erase of selected page
// - halt CPU for halting-region programming
// - plain store fills buffer word
// - four-cycle window, held while programming
// - only permitted patterns are accepted
// - one store operation at a time
module flash_spm_device #(
  parameter int unsigned progCycles = flash_spm_pkg::PROG_CYCLES_DEFAULT,
  parameter logic [7:0]  fuseByte   = 8'hFF,
  parameter logic [31:0] sigRow     = 32'h0000_0000  // arbitrary value
) (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  flash_spm_if.device                     link,
  input  wire logic [1:0]                 bootSizeSel,
  output logic [flash_spm_pkg::PC_W-1:0]  bootStart,
  output logic                            flashStart,
  output logic                            flashErase,
  output logic [flash_spm_pkg::PAGE_SEL_W-1:0] flashPage,
  input  wire logic [flash_spm_pkg::WORD_SEL_W-1:0] bufRdAddr,
  output logic [15:0]                     bufRdData
);
  import flash_spm_pkg::*;

  function automatic logic [PC_W-1:0] boot_start(input logic [1:0] code);
    case (code)
      2'b11:   boot_start = BOOT_START_512;
      2'b10:   boot_start = BOOT_START_1024;
      2'b01:   boot_start = BOOT_START_2048;
      default: boot_start = BOOT_START_4096;
    endcase
  endfunction : boot_start

  prog_state_type  state_r;
  logic            irqEn_r;
  logic            busy_r;
  logic [5:1]      cmd_r;
  logic            store_enable_bit_r;
  logic [2:0]      winCnt_r;
  logic [1:0]      loadCnt_r;
  logic [15:0]     progCnt_r;
  logic            halt_r;
  logic            bufValid_r;
  logic [7:0]      lock_r;
  logic [15:0]     pageBuf [PAGE_WORDS];

  wire logic [4:0]            csrLow     = link.csrWdata[4:0];
  wire logic                  patternOk  = csrLow == PAT_REEN || csrLow == PAT_LOCK || csrLow == PAT_PWRITE ||
                                           csrLow == PAT_PERASE || csrLow == PAT_FILL;
  wire logic                  accept     = link.csrWrite && state_r == IDLE && patternOk;
  wire logic [PC_W-1:0]       pc         = {link.extPage, link.ptr[15:1]};
  wire logic [PAGE_SEL_W-1:0] pageSel    = pc[PC_W-1:WORD_SEL_W];
  wire logic [WORD_SEL_W-1:0] wordSel    = pc[WORD_SEL_W-1:0];
  wire logic                  inHalting  = pc >= HALT_REGION_START;
  wire logic                  storeHit   = link.storeReq && store_enable_bit_r && winCnt_r != 3'h0 && state_r == IDLE;
  wire logic                  isErase    = cmd_r[BIT_PERASE];
  wire logic                  isWrite    = cmd_r[BIT_PWRITE];
  wire logic                  isLock     = cmd_r[BIT_LOCK];
  wire logic                  isReen     = cmd_r[BIT_REEN];
  wire logic                  isSig      = cmd_r[BIT_SIG];
  wire logic                  isFill     = cmd_r == 5'h00;
  wire logic                  progStart  = storeHit && (isErase || isWrite);
  wire logic                  progDone   = state_r == PROG && progCnt_r == 16'h0001;
  wire logic                  windowEnd  = state_r == IDLE && winCnt_r == 3'h1;
  wire logic                  storeDone  = storeHit && !isSig && !progStart;
  wire logic                  loadHit    = link.loadReq && store_enable_bit_r && loadCnt_r != 2'h0 && (isSig || isLock);
  wire logic [7:0]            sigByte    = sigRow[8*link.ptr[1:0] +: 8];
  wire logic [7:0]            lockOrFuse = link.ptr[0] ? fuseByte : lock_r;

  // store enable, command bits and the two windows
  always_ff @(posedge clk) begin
    if (!nrst) begin
      store_enable_bit_r   <= 1'b0;
      cmd_r     <= 5'h00;
      winCnt_r  <= 3'h0;
      loadCnt_r <= 2'h0;
    end else if (accept) begin
      store_enable_bit_r   <= 1'b1;
      cmd_r     <= link.csrWdata[5:1];
      winCnt_r  <= STORE_WINDOW;
      loadCnt_r <= LOAD_WINDOW;
    end else if (progStart) begin
      // a start on the last window cycle must not let the expiry drop the enable
      winCnt_r  <= 3'h0;
      loadCnt_r <= 2'h0;
    end else if (progDone || storeDone || loadHit || windowEnd) begin
      store_enable_bit_r   <= 1'b0;
      cmd_r     <= 5'h00;
      winCnt_r  <= 3'h0;
      loadCnt_r <= 2'h0;
    end else if (state_r == IDLE && winCnt_r != 3'h0) begin
      winCnt_r  <= winCnt_r - 3'h1;
      loadCnt_r <= (loadCnt_r == 2'h0) ? 2'h0 : loadCnt_r - 2'h1;
    end
  end

  // erase/write sequencer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r   <= IDLE;
      progCnt_r <= 16'h0000;
      halt_r    <= 1'b0;
    end else begin
      case (state_r)
        IDLE: begin
          if (progStart) begin
            state_r   <= PROG;
            progCnt_r <= 16'(progCycles);
            halt_r    <= inHalting;
          end
        end
        PROG: begin
          progCnt_r <= progCnt_r - 16'h0001;
          if (progDone) begin
            state_r <= IDLE;
            halt_r  <= 1'b0;
          end
        end
        default: state_r <= IDLE;
      endcase
    end
  end

  // region busy flag and buffer occupancy
  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy_r     <= 1'b0;
      bufValid_r <= 1'b0;
    end else begin
      if (progStart && !inHalting)
        busy_r <= 1'b1;
      else if (storeDone && (isReen || isFill))
        busy_r <= 1'b0;
      if (storeDone && isFill)
        bufValid_r <= 1'b1;
      else if ((accept && csrLow == PAT_REEN) || (progDone && isWrite))
        bufValid_r <= 1'b0;
    end
  end

  // temporary page buffer
  always_ff @(posedge clk) begin
    if (storeDone && isFill)
      pageBuf[wordSel] <= {link.gpHighData, link.gpLowData};
  end

  always_ff @(posedge clk) begin
    if (!nrst)
      bufRdData <= 16'h0000;
    else
      bufRdData <= bufValid_r ? pageBuf[bufRdAddr] : 16'hFFFF;
  end

  // lock bits: only boot lock bits may be programmed, towards zero
  always_ff @(posedge clk) begin
    if (!nrst)
      lock_r <= LOCK_RESET;
    else if (storeDone && isLock)
      lock_r <= lock_r & {2'b11, link.gpLowData[5:2], 2'b11};
  end

  // outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irqEn_r          <= 1'b0;
      link.csrRdata    <= CSR_RESET;
      link.loadData    <= 8'h00;
      link.loadSpecial <= 1'b0;
      link.readyIrq    <= 1'b0;
      link.regionBusy  <= 1'b0;
      link.cpuHalt     <= 1'b0;
      bootStart        <= BOOT_START_4096;
      flashStart       <= 1'b0;
      flashErase       <= 1'b0;
      flashPage        <= '0;
    end else begin
      if (link.csrWrite && state_r == IDLE)
        irqEn_r <= link.csrWdata[BIT_IRQ_EN];
      link.csrRdata    <= {irqEn_r, busy_r, cmd_r, store_enable_bit_r};
      link.loadSpecial <= loadHit;
      if (loadHit)
        link.loadData <= isSig ? sigByte : lockOrFuse;
      link.readyIrq    <= irqEn_r && link.globalIrqEn && !store_enable_bit_r;
      link.regionBusy  <= busy_r;
      link.cpuHalt     <= halt_r;
      bootStart        <= boot_start(bootSizeSel);
      flashStart       <= progStart;
      if (progStart) begin
        flashErase <= isErase;
        flashPage  <= pageSel;
      end
    end
  end
endmodule : flash_spm_device

// ### hdl/flash_spm_cpu.sv
`timescale 1ns/1ns
// APB-controlled stand-in for the core that issues store/load operations
module flash_spm_cpu (
  input  wire logic        clk,
  input  wire logic        nrst,
  flash_spm_if.cpu         link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  import flash_spm_pkg::*;

  logic       storePend_r;
  logic       loadPend_r;
  logic       gie_r;

  wire logic access = psel && penable && !pready;
  wire logic wrAcc  = access && pwrite;
  wire logic mapped = paddr == OFS_CSR || paddr == OFS_PTR || paddr == OFS_DATA || paddr == OFS_OP ||
                      paddr == OFS_STATUS || paddr == OFS_GIE;
  wire logic [31:0] rdMux =
    (paddr == OFS_CSR)    ? {24'h00_0000, link.csrRdata} :
    (paddr == OFS_PTR)    ? {14'h0000, link.extPage, link.ptr} :
    (paddr == OFS_DATA)   ? {16'h0000, link.gpHighData, link.gpLowData} :
    (paddr == OFS_OP)     ? {30'h0000_0000, loadPend_r, storePend_r} :
    (paddr == OFS_STATUS) ? {12'h000, link.cpuHalt, link.regionBusy, link.readyIrq, 1'b0,
                             link.loadData, link.csrRdata} :
    (paddr == OFS_GIE)    ? {31'h0000_0000, gie_r} : 32'h0000_0000;
  // a pending operation waits while the core is halted
  wire logic issue = !link.cpuHalt && !link.storeReq && !link.loadReq && !link.csrWrite;
  // an operation leaves at its own write when the core is free, so a load meets its window
  wire logic opWr      = wrAcc && paddr == OFS_OP;
  wire logic storeWant = storePend_r || (opWr && pwdata[OP_STORE]);
  wire logic loadWant  = loadPend_r || (opWr && pwdata[OP_LOAD]);
  wire logic storeNow  = storeWant && issue;
  wire logic loadNow   = loadWant && !storeWant && issue;

  // APB answer: one wait state
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access;
      pslverr <= access && !mapped;
      if (access && !pwrite)
        prdata <= rdMux;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      link.csrWrite   <= 1'b0;
      link.csrWdata   <= CSR_RESET;
      link.ptr        <= 16'h0000;
      link.extPage    <= 2'h0;
      link.gpLowData  <= 8'h00;
      link.gpHighData <= 8'h00;
      gie_r           <= 1'b0;
    end else begin
      link.csrWrite <= wrAcc && paddr == OFS_CSR;
      if (wrAcc && paddr == OFS_CSR)
        link.csrWdata <= pwdata[7:0];
      if (wrAcc && paddr == OFS_PTR) begin
        link.ptr     <= pwdata[15:0];
        link.extPage <= pwdata[17:16];
      end
      if (wrAcc && paddr == OFS_DATA) begin
        link.gpLowData  <= pwdata[7:0];
        link.gpHighData <= pwdata[15:8];
      end
      if (wrAcc && paddr == OFS_GIE)
        gie_r <= pwdata[0];
    end
  end

  assign link.globalIrqEn = gie_r;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      storePend_r   <= 1'b0;
      loadPend_r    <= 1'b0;
      link.storeReq <= 1'b0;
      link.loadReq  <= 1'b0;
    end else begin
      link.storeReq <= storeNow;
      link.loadReq  <= loadNow;
      storePend_r   <= storeWant && !storeNow;
      loadPend_r    <= loadWant && !loadNow;
    end
  end
endmodule : flash_spm_cpu

// ### test/flash_spm_asserts.sv
`timescale 1ns/1ns
module flash_spm_asserts (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        csrWrite,
  input wire logic [7:0]  csrWdata,
  input wire logic [7:0]  csrRdata,
  input wire logic        storeReq,
  input wire logic        loadReq,
  input wire logic [15:0] ptr,
  input wire logic [1:0]  extPage,
  input wire logic        globalIrqEn,
  input wire logic        loadSpecial,
  input wire logic        readyIrq,
  input wire logic        regionBusy,
  input wire logic        cpuHalt
);
  import flash_spm_pkg::*;
  // word address bits 16:12 of the targeted page
  wire [4:0] topBits = {extPage, ptr[15:13]};
  wire       badPat  = !(csrWdata[4:0] inside {PAT_REEN, PAT_LOCK, PAT_PWRITE, PAT_PERASE, PAT_FILL});
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  irq_level_a: assert property (readyIrq == (csrRdata[7] && !csrRdata[0] && $past(globalIrqEn)))
    else $error("ready interrupt level wrong");
  halt_source_a: assert property ($rose(cpuHalt) |-> $past(storeReq, 2) && $past(topBits, 2) == 5'h1F)
    else $error("halt without halting-region store");
  busy_source_a: assert property ($rose(regionBusy) |-> $past(storeReq, 2) && $past(topBits, 2) != 5'h1F)
    else $error("busy without concurrent-region store");
  busy_clear_a: assert property ($fell(regionBusy) |-> $past(storeReq) || $past(storeReq, 2) || $past(storeReq, 3))
    else $error("busy cleared without store");
  load_answer_a: assert property (loadSpecial |-> $past(loadReq))
    else $error("special load without request");
  store_window_a: assert property ($rose(csrRdata[0]) |-> ##[1:6] (!csrRdata[0] || cpuHalt || regionBusy))
    else $error("store enable outlived its window");
  bad_pattern_a: assert property (csrWrite && badPat && !csrRdata[0] |-> ##2 !csrRdata[0])
    else $error("illegal pattern accepted");
  prog_hold_a: assert property ($rose(cpuHalt) |-> csrRdata[0])
    else $error("enable dropped during programming");
endmodule : flash_spm_asserts

// ### test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import flash_spm_pkg::*;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr, flashStart, flashErase, er, err, haltSeen;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  bootSizeSel;
  logic [16:0] bootStart;
  logic [9:0]  flashPage, pg;
  logic [6:0]  bufRdAddr;
  logic [15:0] bufRdData;
  logic [16:0] bootExp [4] = '{BOOT_START_4096, BOOT_START_2048, BOOT_START_1024, BOOT_START_512};
  int          n_fail = 0;
  int          checks_done = 0;
  int          cycles = 0;
  localparam logic [31:0] SIG_ROW_TB = 32'h0302_0100;  // arbitrary signature bytes

  flash_spm_if link ();
  flash_spm_cpu flash_spm_cpu_inst (.clk(clk), .nrst(nrst), .link(link), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  flash_spm_device #(.progCycles(8), .sigRow(SIG_ROW_TB)) flash_spm_device_inst (.clk(clk), .nrst(nrst), .link(link),
    .bootSizeSel(bootSizeSel), .bootStart(bootStart), .flashStart(flashStart), .flashErase(flashErase),
    .flashPage(flashPage), .bufRdAddr(bufRdAddr), .bufRdData(bufRdData));
  flash_spm_asserts flash_spm_asserts_inst (.clk(clk), .nrst(nrst), .csrWrite(link.csrWrite),
    .csrWdata(link.csrWdata), .csrRdata(link.csrRdata), .storeReq(link.storeReq), .loadReq(link.loadReq),
    .ptr(link.ptr), .extPage(link.extPage), .globalIrqEn(link.globalIrqEn), .loadSpecial(link.loadSpecial),
    .readyIrq(link.readyIrq), .regionBusy(link.regionBusy), .cpuHalt(link.cpuHalt));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (flashStart === 1'b1) begin
      pg <= flashPage;
      er <= flashErase;
    end
    if (link.cpuHalt === 1'b1) haltSeen <= 1'b1;
    if (cycles == 5000) begin
      n_fail++;
      print_verdict();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // request held until pready is sampled; psel stays up so a transfer may follow at once
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task idle;
    psel <= 1'b0;
    @(posedge clk);
  endtask : idle

  // poll status until the store enable reads clear
  task waitDone;
    do apb(1'b0, OFS_STATUS, 32'h0); while (rd[0] !== 1'b0);
  endtask : waitDone

  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  initial begin
    nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    bootSizeSel = 2'h0; bufRdAddr = 7'h00; haltSeen = 1'b0; pg = 10'h000; er = 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      bootSizeSel <= i[1:0];
      repeat (2) @(posedge clk);
      chk({15'h0, bootStart}, {15'h0, bootExp[i]});
    end
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(err), 32'h1);
    wr(OFS_GIE, 32'h1);
    wr(OFS_CSR, 32'h80);
    wr(OFS_CSR, 32'h87);
    idle();
    repeat (4) @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(rd[7:0]), 32'h80);
    chk(32'(rd[17]), 32'h1);
    wr(OFS_PTR, 32'h0106);
    wr(OFS_DATA, 32'h1234);
    wr(OFS_CSR, 32'h01);
    wr(OFS_OP, 32'h1);
    waitDone();
    idle();
    bufRdAddr <= 7'h03;
    repeat (2) @(posedge clk);
    chk(32'(bufRdData), 32'h1234);
    wr(OFS_PTR, 32'h0200);
    wr(OFS_CSR, 32'h03);
    wr(OFS_OP, 32'h1);
    waitDone();
    chk(32'(rd[18]), 32'h1);
    chk({21'h0, er, pg}, 32'h0402);
    wr(OFS_CSR, 32'h11);
    wr(OFS_OP, 32'h1);
    waitDone();
    idle();
    repeat (3) @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(rd[18]), 32'h0);
    chk(32'(bufRdData), 32'hFFFF);
    wr(OFS_PTR, 32'h3_E000);
    wr(OFS_CSR, 32'h05);
    wr(OFS_OP, 32'h1);
    waitDone();
    chk({20'h0, haltSeen, er, pg}, 32'h0000_0BE0);
    chk(32'(rd[18]), 32'h0);
    wr(OFS_DATA, 32'h0);
    wr(OFS_PTR, 32'h0);
    wr(OFS_CSR, 32'h09);
    wr(OFS_OP, 32'h1);
    waitDone();
    wr(OFS_CSR, 32'h09);
    wr(OFS_OP, 32'h2);
    waitDone();
    chk(32'(rd[15:8]), 32'(LOCK_RESET & 8'hC3));
    wr(OFS_PTR, 32'h1);
    wr(OFS_CSR, 32'h09);
    wr(OFS_OP, 32'h2);
    waitDone();
    chk(32'(rd[15:8]), 32'hFF);
    wr(OFS_PTR, 32'h2);
    wr(OFS_CSR, 32'h21);
    wr(OFS_OP, 32'h2);
    waitDone();
    chk(32'(rd[15:8]), 32'(SIG_ROW_TB[23:16]));
    idle();
    print_verdict();
  end
endmodule : tb_top
